/* File: hdl/slts_core.sv */
// Chosen here: the strobed register port.
`timescale 1ns/10ps
// Function
// - selector zero passes normal converter data, all test patterns off
// - codes 1, 2, 3 send PRBS7, PRBS15, PRBS23 on lanes
// - code 4 sends a ramp, code 5 the transport test pattern
// - code 8 repeats alignment sequence, 9 modified RPAT, 16 repeats K28.7
// - code 10 holds outputs low, code 11 holds them high
// - codes 13 and 14 send PRBS9 and PRBS31
// - code 15 sends eight zeros then eight ones per word
// - identifier byte is sent in second multiframe of alignment sequence
// - comma selector picks K28.7, K28.1, K28.5; code 3 reserved
// - end-of-frame comma replaces final character only when data allows
// - status bit 6 high while link is up
// - status bit 5 is sync request level, zero when asserted
// - status bit 4 sticky on SYSREF realignment, cleared by writing one
// - status bit 3 set by first SYSREF after enable, write one clears
// - status bit 2 shows serializer pll lock
// - status bit 0 shows sampling pll lock
module slts_core (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // framer side, one character per cycle
  input  wire logic [7:0]  data_char,
  input  wire logic [7:0]  ila_char,
  input  wire logic        ila_char_k,
  input  wire logic        ila_ident_slot,
  input  wire logic        frame_last,
  input  wire logic        frame_end_ok,
  // status sources
  input  wire logic        link_up_in,
  input  wire logic        sync_req_n_pin,
  input  wire logic        sysref_realign,
  input  wire logic        sysref_event,
  input  wire logic        serializer_pll_lock,
  input  wire logic        sampling_pll_lock,
  // lane output
  output logic      [7:0]  lane_char,
  output logic             lane_char_k,
  output logic             lane_force,
  output logic             lane_force_level,
  output logic      [4:0]  link_test_select,
  output logic             link_enable_bit
);

  // ==========================================================
  // registers
  logic [7:0]  test_reg, test_next;
  logic [7:0]  ident_reg, ident_next;
  logic [7:0]  comma_reg, comma_next;
  logic [7:0]  ctrl_reg, ctrl_next;
  logic        realign_reg, realign_next;
  logic        mfset_reg, mfset_next;
  logic        armed_reg, armed_next;
  logic [2:0]  sync_sh_reg;
  logic        sync_lvl_reg;
  logic [7:0]  rdata_reg, rdata_next;
  logic [30:0] lfsr_reg, lfsr_next;
  logic [7:0]  ramp_reg;
  logic        half_reg;
  logic [7:0]  char_reg, char_next;
  logic        k_reg, k_next;
  logic        force_reg, force_next;
  logic        level_reg, level_next;

  // ==========================================================
  // address decode
  wire sel_test = (reg_addr == slts_pkg::ADDR_TEST_SEL);
  wire sel_id   = (reg_addr == slts_pkg::ADDR_IDENT);
  wire sel_cm   = (reg_addr == slts_pkg::ADDR_COMMA);
  wire sel_st   = (reg_addr == slts_pkg::ADDR_STATUS);
  wire sel_ct   = (reg_addr == slts_pkg::ADDR_LINK_CTRL);
  wire wr_st    = reg_wr && sel_st;

  wire       link_en   = ctrl_reg[slts_pkg::CTRL_LINK_EN];
  wire       mode_8b   = ctrl_reg[slts_pkg::CTRL_MODE_8B10B];
  wire [4:0] tsel      = test_reg[4:0];
  wire [1:0] csel      = comma_reg[1:0];
  // pin level taken only once second and third flops agree
  wire       sync_agree = (sync_sh_reg[1] == sync_sh_reg[2]);
  wire       sync_lvl   = sync_lvl_reg;

  // reserved selector codes fall back to normal
  function automatic logic code_valid(input logic [4:0] c);
    code_valid = (c <= 5'h10) && (c != 5'h0C);
  endfunction

  wire [4:0] tsel_eff = code_valid(tsel) ? tsel : 5'h00;

  // ==========================================================
  // status word
  wire [7:0] status_word = {1'b0,
                            link_up_in,
                            sync_lvl,
                            realign_reg,
                            mfset_reg,
                            serializer_pll_lock,
                            1'b0,
                            sampling_pll_lock};

  always_comb begin
    test_next  = test_reg;
    ident_next = ident_reg;
    comma_next = comma_reg;
    ctrl_next  = ctrl_reg;
    if (reg_wr && sel_test) begin
      test_next = {3'h0, reg_wdata[4:0]};
    end else if (reg_wr && sel_id) begin
      ident_next = reg_wdata;
    end else if (reg_wr && sel_cm) begin
      comma_next = {6'h00, reg_wdata[1:0]};
    end else if (reg_wr && sel_ct) begin
      ctrl_next = {6'h00, reg_wdata[1:0]};
    end
  end

  // sticky bits: hardware set wins over write-one clear
  always_comb begin
    realign_next = realign_reg;
    if (wr_st && reg_wdata[slts_pkg::ST_REALIGNED]) realign_next = 1'b0;
    if (sysref_realign) realign_next = 1'b1;
  end

  always_comb begin
    mfset_next = mfset_reg;
    armed_next = armed_reg;
    if (!link_en) armed_next = 1'b1;
    if (wr_st && reg_wdata[slts_pkg::ST_MF_PHASE_SET]) mfset_next = 1'b0;
    if (link_en && armed_reg && sysref_event) begin
      mfset_next = 1'b1;
      armed_next = 1'b0;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      if (sel_test) rdata_next = test_reg;
      else if (sel_id) rdata_next = ident_reg;
      else if (sel_cm) rdata_next = comma_reg;
      else if (sel_st) rdata_next = status_word;
      else if (sel_ct) rdata_next = ctrl_reg;
      else rdata_next = 8'h00;
    end
  end

  // ==========================================================
  // pattern generators: one shared 31-bit lfsr, taps per mode
  function automatic logic prbs_fb(input logic [30:0] s, input logic [4:0] c);
    case (c)
      slts_pkg::SLTS_TP_PRBS7:  prbs_fb = s[6] ^ s[5];
      slts_pkg::SLTS_TP_PRBS9:  prbs_fb = s[8] ^ s[4];
      slts_pkg::SLTS_TP_PRBS15: prbs_fb = s[14] ^ s[13];
      slts_pkg::SLTS_TP_PRBS23: prbs_fb = s[22] ^ s[17];
      default:                  prbs_fb = s[30] ^ s[27];
    endcase
  endfunction

  always_comb begin
    lfsr_next = lfsr_reg;
    for (int i = 0; i < 8; i++) begin
      lfsr_next = {lfsr_next[29:0], prbs_fb(lfsr_next, tsel_eff)};
    end
  end

  wire [7:0] comma_char = (csel == 2'h1) ? slts_pkg::CHAR_K281 :
                          (csel == 2'h2) ? slts_pkg::CHAR_K285 :
                          slts_pkg::CHAR_K287;
  wire       comma_ok   = mode_8b && (csel != 2'h3) && frame_last && frame_end_ok;
  wire [7:0] clk_byte   = half_reg ? slts_pkg::CLOCK_WORD[7:0] : slts_pkg::CLOCK_WORD[15:8];

  // ==========================================================
  // lane character select
  always_comb begin
    char_next  = data_char;
    k_next     = 1'b0;
    force_next = 1'b0;
    level_next = 1'b0;
    case (tsel_eff)
      slts_pkg::SLTS_TP_NORMAL: begin
        if (ila_ident_slot) begin
          char_next = ident_reg;
        end else if (comma_ok) begin
          char_next = comma_char;
          k_next    = 1'b1;
        end else begin
          char_next = data_char;
        end
      end
      slts_pkg::SLTS_TP_PRBS7, slts_pkg::SLTS_TP_PRBS15,
      slts_pkg::SLTS_TP_PRBS23: char_next = lfsr_reg[7:0];
      slts_pkg::SLTS_TP_PRBS9,
      slts_pkg::SLTS_TP_PRBS31: char_next = lfsr_reg[7:0];
      slts_pkg::SLTS_TP_RAMP:   char_next = ramp_reg;
      slts_pkg::SLTS_TP_TRANSP: char_next = ramp_reg ^ ident_reg;
      slts_pkg::SLTS_TP_D215:   char_next = slts_pkg::CHAR_D215;
      slts_pkg::SLTS_TP_K285: begin
        char_next = slts_pkg::CHAR_K285;
        k_next    = 1'b1;
      end
      slts_pkg::SLTS_TP_ILA: begin
        char_next = ila_ident_slot ? ident_reg : ila_char;
        k_next    = ila_char_k & ~ila_ident_slot;
      end
      slts_pkg::SLTS_TP_RPAT:   char_next = {ramp_reg[3:0], ~ramp_reg[3:0]};
      slts_pkg::SLTS_TP_K287: begin
        char_next = slts_pkg::CHAR_K287;
        k_next    = 1'b1;
      end
      slts_pkg::SLTS_TP_LOW: begin
        force_next = 1'b1;
        level_next = 1'b0;
      end
      slts_pkg::SLTS_TP_HIGH: begin
        force_next = 1'b1;
        level_next = 1'b1;
      end
      slts_pkg::SLTS_TP_CLOCK:  char_next = clk_byte;
      default:                  char_next = data_char;
    endcase
  end

  // ==========================================================
  // flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      test_reg  <= slts_pkg::RST_TEST_SEL;
      ident_reg <= slts_pkg::RST_IDENT;
      comma_reg <= slts_pkg::RST_COMMA;
      ctrl_reg  <= slts_pkg::RST_LINK_CTRL;
    end else begin
      test_reg  <= test_next;
      ident_reg <= ident_next;
      comma_reg <= comma_next;
      ctrl_reg  <= ctrl_next;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      realign_reg <= 1'b0;
      mfset_reg   <= 1'b0;
      armed_reg   <= 1'b1;
      sync_sh_reg <= 3'h0;
      rdata_reg   <= 8'h00;
    end else begin
      realign_reg <= realign_next;
      mfset_reg   <= mfset_next;
      armed_reg   <= armed_next;
      sync_sh_reg <= {sync_sh_reg[1:0], sync_req_n_pin};
      rdata_reg   <= rdata_next;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_lvl_reg <= 1'b0;
    end else if (sync_agree) begin
      sync_lvl_reg <= sync_sh_reg[2];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lfsr_reg <= 31'h7FFFFFFF;
      ramp_reg <= 8'h00;
      half_reg <= 1'b0;
    end else begin
      lfsr_reg <= (lfsr_next == 31'h0) ? 31'h7FFFFFFF : lfsr_next;
      ramp_reg <= ramp_reg + 8'h01;
      half_reg <= ~half_reg;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      char_reg  <= 8'h00;
      k_reg     <= 1'b0;
      force_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      char_reg  <= char_next;
      k_reg     <= k_next;
      force_reg <= force_next;
      level_reg <= level_next;
    end
  end

  assign reg_rdata        = rdata_reg;
  assign lane_char        = char_reg;
  assign lane_char_k      = k_reg;
  assign lane_force       = force_reg;
  assign lane_force_level = level_reg;
  assign link_test_select = tsel_eff;
  assign link_enable_bit  = link_en;

endmodule

/* File: hdl/slts_pkg.sv */
package slts_pkg;

  // ==========================================================
  // register offsets (byte addresses on the 12-bit port)
  localparam logic [11:0] ADDR_TEST_SEL   = 12'h205;
  localparam logic [11:0] ADDR_IDENT      = 12'h206;
  localparam logic [11:0] ADDR_COMMA      = 12'h207;
  localparam logic [11:0] ADDR_STATUS     = 12'h208;
  localparam logic [11:0] ADDR_LINK_CTRL  = 12'h300;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_TEST_SEL  = 8'h00;
  localparam logic [7:0] RST_IDENT     = 8'h00;
  localparam logic [7:0] RST_COMMA     = 8'h00;
  localparam logic [7:0] RST_LINK_CTRL = 8'h00;

  // ==========================================================
  // field positions
  localparam int TEST_SEL_W      = 5;
  localparam int COMMA_SEL_W     = 2;
  localparam int ST_LINK_UP      = 6;
  localparam int ST_SYNC         = 5;
  localparam int ST_REALIGNED    = 4;
  localparam int ST_MF_PHASE_SET = 3;
  localparam int ST_SER_LOCK     = 2;
  localparam int ST_SAMP_LOCK    = 0;
  localparam int CTRL_LINK_EN    = 0;
  localparam int CTRL_MODE_8B10B = 1;

  // ==========================================================
  // test selector codes
  typedef enum logic [4:0] {
    SLTS_TP_NORMAL = 5'h00,
    SLTS_TP_PRBS7  = 5'h01,
    SLTS_TP_PRBS15 = 5'h02,
    SLTS_TP_PRBS23 = 5'h03,
    SLTS_TP_RAMP   = 5'h04,
    SLTS_TP_TRANSP = 5'h05,
    SLTS_TP_D215   = 5'h06,
    SLTS_TP_K285   = 5'h07,
    SLTS_TP_ILA    = 5'h08,
    SLTS_TP_RPAT   = 5'h09,
    SLTS_TP_LOW    = 5'h0A,
    SLTS_TP_HIGH   = 5'h0B,
    SLTS_TP_PRBS9  = 5'h0D,
    SLTS_TP_PRBS31 = 5'h0E,
    SLTS_TP_CLOCK  = 5'h0F,
    SLTS_TP_K287   = 5'h10
  } slts_pattern_t;

  // ==========================================================
  // control characters (8-bit payload, k flag separate)
  localparam logic [7:0]  CHAR_K287   = 8'hFC;
  localparam logic [7:0]  CHAR_K281   = 8'h3C;
  localparam logic [7:0]  CHAR_K285   = 8'hBC;
  localparam logic [7:0]  CHAR_D215   = 8'hB5;
  localparam logic [15:0] CLOCK_WORD  = 16'h00FF;

endpackage

/* File: tb/slts_monitor.sv */
`timescale 1ns/10ps
// ==========================================
// port checker
module slts_monitor (
  // clock and reset
  input wire logic       clock,
  input wire logic       rstn,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // framer and status inputs
  input wire logic [7:0] data_char,
  input wire logic       frame_last,
  input wire logic       ila_ident_slot,
  input wire logic       link_up_in,
  input wire logic       serializer_pll_lock,
  input wire logic       sampling_pll_lock,
  // lane side
  input wire logic [7:0] lane_char,
  input wire logic       lane_char_k,
  input wire logic       lane_force,
  input wire logic       lane_force_level,
  input wire logic [4:0] link_test_select
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence status_read;
    reg_rd && reg_addr == slts_pkg::ADDR_STATUS;
  endsequence
  sequence inputs_steady;
    $stable(link_up_in) && $stable(serializer_pll_lock) && $stable(sampling_pll_lock);
  endsequence

  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  chk_sel_legal: assert property (link_test_select != 5'h0C && link_test_select <= 5'h10)
    else $error("reserved selector code is active");
  chk_normal_data: assert property (link_test_select == 5'h00 && !frame_last && !ila_ident_slot
    |=> lane_char == $past(data_char) && !lane_char_k && !lane_force)
    else $error("normal mode does not pass data");
  chk_k285_repeat: assert property (link_test_select == 5'h07
    |=> lane_char == slts_pkg::CHAR_K285 && lane_char_k)
    else $error("comma repeat mode wrong");
  chk_k287_repeat: assert property (link_test_select == 5'h10
    |=> lane_char == slts_pkg::CHAR_K287 && lane_char_k)
    else $error("frame comma repeat mode wrong");
  chk_force_low: assert property (link_test_select == 5'h0A |=> lane_force && !lane_force_level)
    else $error("outputs not held low");
  chk_force_high: assert property (link_test_select == 5'h0B |=> lane_force && lane_force_level)
    else $error("outputs not held high");
  chk_force_off: assert property (link_test_select != 5'h0A && link_test_select != 5'h0B
    |=> !lane_force)
    else $error("static level forced outside its modes");
  chk_clock_alt: assert property ((link_test_select == 5'h0F)[*2]
    |=> lane_char != $past(lane_char) && (lane_char == 8'h00 || lane_char == 8'hFF))
    else $error("clock pattern does not alternate");
  chk_status_live: assert property (status_read ##0 inputs_steady
    |=> reg_rdata[6] == $past(link_up_in) && reg_rdata[2] == $past(serializer_pll_lock)
        && reg_rdata[0] == $past(sampling_pll_lock))
    else $error("status levels wrong");
  chk_status_resv: assert property (status_read |=> !reg_rdata[7] && !reg_rdata[1])
    else $error("reserved status bits set");
endmodule

bind slts_core slts_monitor slts_monitor_i (.clock, .rstn, .reg_addr, .reg_rd, .reg_rdata,
  .data_char, .frame_last, .ila_ident_slot, .link_up_in, .serializer_pll_lock,
  .sampling_pll_lock, .lane_char, .lane_char_k, .lane_force, .lane_force_level,
  .link_test_select);

/* File: tb/slts_rx_model.sv */
`timescale 1ns/10ps
// ==========================================
// receiver: requests sync until four K28.5 commas seen in a row
module slts_rx_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // lane
  input  wire logic [7:0] lane_char,
  input  wire logic       lane_char_k,
  // sync request, low while requesting
  output wire logic       sync_req_n_pin
);
  logic [2:0] comma_cnt_reg;
  wire logic  is_comma = lane_char_k && lane_char == slts_pkg::CHAR_K285;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      comma_cnt_reg <= 3'h0;
    else if (comma_cnt_reg != 3'h4)
      comma_cnt_reg <= is_comma ? comma_cnt_reg + 3'h1 : 3'h0;
  end
  assign sync_req_n_pin = (comma_cnt_reg == 3'h4);
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
  // ==========================================
  // signals
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  data_char = 8'h5A;
  logic [7:0]  ila_char = 8'h1C;
  logic        ila_char_k = 1'b1;
  logic        ila_ident_slot = 1'b0;
  logic        frame_last = 1'b0;
  logic        frame_end_ok = 1'b0;
  logic        link_up_in = 1'b0;
  logic        sysref_realign = 1'b0;
  logic        sysref_event = 1'b0;
  logic        serializer_pll_lock = 1'b0;
  logic        sampling_pll_lock = 1'b0;
  logic [7:0]  prev;
  logic [7:0]  commas [4] = '{slts_pkg::CHAR_K287, slts_pkg::CHAR_K281,
                             slts_pkg::CHAR_K285, 8'h5A};
  wire logic [7:0] reg_rdata, lane_char;
  wire logic [4:0] link_test_select;
  wire logic   lane_char_k, lane_force, lane_force_level, link_enable_bit, sync_req_n_pin;
  int          fail_count = 0;
  int          n_tests = 0;

  slts_core slts_core_i (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .data_char, .ila_char, .ila_char_k, .ila_ident_slot, .frame_last, .frame_end_ok,
    .link_up_in, .sync_req_n_pin, .sysref_realign, .sysref_event, .serializer_pll_lock,
    .sampling_pll_lock, .lane_char, .lane_char_k, .lane_force, .lane_force_level,
    .link_test_select, .link_enable_bit);
  slts_rx_model slts_rx_model_i (.clock, .rstn, .lane_char, .lane_char_k, .sync_req_n_pin);

  always #25 clock = ~clock;

  // ==========================================
  // access tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic lane(input logic [7:0] c, input logic k);
    @(posedge clock);
    #1 check(lane_char, c);
    check({7'h00, lane_char_k}, {7'h00, k});
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #(5000 * 50);
    fail_count++;
    finish_test;
  end

  // ==========================================
  // tests
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    rd(slts_pkg::ADDR_TEST_SEL, 8'h00);
    rd(slts_pkg::ADDR_IDENT, 8'h00);
    rd(slts_pkg::ADDR_COMMA, 8'h00);
    rd(12'h2FF, 8'h00);
    rd(slts_pkg::ADDR_STATUS, 8'h00);
    wr(slts_pkg::ADDR_TEST_SEL, 8'hFF);
    rd(slts_pkg::ADDR_TEST_SEL, 8'h1F);
    lane(8'h5A, 1'b0);
    for (int i = 0; i < 17; i++) begin
      wr(slts_pkg::ADDR_TEST_SEL, i[7:0]);
      #1 check({3'h0, link_test_select}, (i == 12) ? 8'h00 : i[7:0]);
      case (i)
        0, 12: lane(8'h5A, 1'b0);
        6: lane(slts_pkg::CHAR_D215, 1'b0);
        7: begin
          repeat (6) @(posedge clock);
          lane(slts_pkg::CHAR_K285, 1'b1);
        end
        10, 11: begin
          @(posedge clock);
          #1 check({6'h00, lane_force, lane_force_level}, {6'h00, 1'b1, i[0]});
        end
        15: begin
          @(posedge clock);
          #1 prev = lane_char;
          lane(~prev, 1'b0);
        end
        16: lane(slts_pkg::CHAR_K287, 1'b1);
        default: ;
      endcase
    end
    wr(slts_pkg::ADDR_IDENT, 8'hA7);
    wr(slts_pkg::ADDR_TEST_SEL, 8'h08);
    lane(8'h1C, 1'b1);
    ila_ident_slot <= 1'b1;
    lane(8'hA7, 1'b0);
    ila_ident_slot <= 1'b0;
    rd(slts_pkg::ADDR_IDENT, 8'hA7);
    wr(slts_pkg::ADDR_TEST_SEL, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(slts_pkg::ADDR_COMMA, c[7:0]);
      wr(slts_pkg::ADDR_LINK_CTRL, 8'h03);
      #1 check({7'h00, link_enable_bit}, 8'h01);
      frame_last <= 1'b1;
      frame_end_ok <= 1'b1;
      lane(commas[c], c != 3);
      frame_end_ok <= 1'b0;
      lane(8'h5A, 1'b0);
      frame_last <= 1'b0;
      wr(slts_pkg::ADDR_LINK_CTRL, 8'h00);
    end
    link_up_in <= 1'b1;
    serializer_pll_lock <= 1'b1;
    sampling_pll_lock <= 1'b1;
    sysref_event <= 1'b1;
    @(posedge clock);
    sysref_event <= 1'b0;
    rd(slts_pkg::ADDR_STATUS, 8'h65);
    wr(slts_pkg::ADDR_LINK_CTRL, 8'h01);
    sysref_event <= 1'b1;
    sysref_realign <= 1'b1;
    @(posedge clock);
    sysref_event <= 1'b0;
    sysref_realign <= 1'b0;
    repeat (3) @(posedge clock);
    rd(slts_pkg::ADDR_STATUS, 8'h7D);
    wr(slts_pkg::ADDR_STATUS, 8'h18);
    rd(slts_pkg::ADDR_STATUS, 8'h65);
    link_up_in <= 1'b0;
    sampling_pll_lock <= 1'b0;
    rd(slts_pkg::ADDR_STATUS, 8'h24);
    finish_test;
  end
endmodule
